//--- logic/bgl_pkg.sv
// Constants, field layouts and carrier types of the boolean output logic.
// Assumes a 10 MHz system clock and a word-addressed register port.
package bgl_pkg;

  localparam int NOUT = 8;
  localparam int NGI = 8;
  localparam int NRAIL = 12;
  localparam int NEXT = 15;
  localparam int NLIVE = 18;
  localparam int NTYPE = 36;
  localparam logic [5:0] NTYPE_CODE = 6'h24;

  // Timing: delay and wait limits count in 100 us ticks
  localparam int CLK_NS = 100;
  localparam int TICK_NS = 100000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;

  // Rail-status type codes; sticky variant of type t is t + NLIVE
  localparam int T_PWR_GOOD = 0;
  localparam int T_OV_FAULT = 1;
  localparam int T_OV_WARN = 2;
  localparam int T_UV_WARN = 3;
  localparam int T_UV_FAULT = 4;
  localparam int T_ON_OVERTIME = 5;
  localparam int T_OFF_OVERTIME = 6;
  localparam int T_OC_FAULT = 7;
  localparam int T_OC_WARN = 8;
  localparam int T_UC_FAULT = 9;
  localparam int T_OT_FAULT = 10;
  localparam int T_OT_WARN = 11;
  localparam int T_SEQ_ON_TO = 12;
  localparam int T_SEQ_OFF_TO = 13;
  localparam int T_WATCHDOG = 14;
  localparam int T_MRG_ACTIVE = 15;
  localparam int T_MRG_DIR = 16;
  localparam int T_SEQ_WAIT = 17;

  // Register map (word index)
  localparam logic [5:0] A_GI_POL = 6'h20;
  localparam logic [5:0] A_SPECIAL = 6'h21;
  localparam logic [5:0] A_MRG_MASK = 6'h22;
  localparam logic [5:0] A_SEQ_LIM = 6'h23;
  localparam logic [5:0] A_IRQ_STAT = 6'h24;
  localparam logic [5:0] A_IRQ_MASK = 6'h25;
  localparam logic [5:0] A_CLR_CMD = 6'h26;
  localparam logic [5:0] A_STATE = 6'h27;
  localparam logic [1:0] SEL_TERM0 = 2'h0;
  localparam logic [1:0] SEL_TERM1 = 2'h1;
  localparam logic [1:0] SEL_CFG = 2'h2;

  // Special-function fields: {enable, pin index[2:0]}
  localparam int SF_SEQ = 0;
  localparam int SF_CLR = 4;
  localparam int SF_MEN = 8;
  localparam int SF_MDIR = 12;
  localparam int LIM_LSB = 0;
  localparam int LIM_RAIL_LSB = 16;
  localparam int ST_CHG_LSB = 0;
  localparam int ST_SEQ_LSB = 8;
  localparam int ST_W = 20;
  localparam int ROW_CODE_LSB = 16;
  localparam int ROW_GI_LSB = 8;

  typedef logic [NRAIL-1:0] bgl_rail_t;

  typedef struct packed {
    logic [11:0] delay;
    logic open_drain;
    logic active_high;
    logic sm_mode;
    logic ignore;
    logic dly_deassert;
    logic dly_assert;
    logic [5:0] type1;
    logic [5:0] type0;
  } bgl_cfg_s;

  typedef struct packed {
    bgl_rail_t rails;
    logic [NGI-1:0] gis;
    logic [NOUT-1:0] outs;
  } bgl_term_s;

  typedef enum logic [1:0] {
    BGL_IDLE,
    BGL_WAIT,
    BGL_HOLD
  } bgl_dly_e;

endpackage

//--- logic/bgl_logic.sv
// Boolean output logic: eight logic outputs built from two AND terms each,
// with delays, sticky rail flags and the special general-input roles.
// Assumes synchronous pins and rail flags from the sequencing engine.
//
// Notes on behaviour
// - Each output is the OR of two AND terms with own input sets; in state machine mode it is one of the two.
// - Terms may use the eight outputs, general inputs and rail flags.
// - One rail-status type per term; any subset of rails of it.
// - Sticky types hold once set until command or clear pin.
// - Types cover good, margin, faults, warnings, timeouts, sticky forms.
// - Delay may apply on assertion, deassertion, both or neither.
// - Without ignore, a change that reverts before the delay never reaches the pin.
// - Ignore option: change starts delay, inputs ignored until expiry.
// - Ignore option: every output pulse lasts at least the delay.
// - State machine mode: path 0 while true, path 1 while false.
// - Each special input role is held by at most one pin.
// - Fault if wait source not active within limit after power good.
// - The clear-source input clears the sticky rail flags.
// - Margin enable puts every margin-enabled rail into margin.
// - Margin direction input selects low when set, high when clear.
// - Each general input has a polarity applied before any use.
// - First three general inputs form the rail state select code.
// - Turn-on overtime flag marks rails late reaching power good.
`timescale 1ns/100ps
`default_nettype none

module bgl_logic (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [5:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rd_data_out,
  input wire logic [bgl_pkg::NGI-1:0] general_input_in,
  input wire bgl_pkg::bgl_rail_t [bgl_pkg::NEXT-1:0] rail_flags_in,
  output logic [bgl_pkg::NOUT-1:0] logic_output_out,
  output logic [bgl_pkg::NOUT-1:0] logic_output_oe_out,
  output logic [bgl_pkg::NRAIL-1:0] margin_active_out,
  output logic [bgl_pkg::NRAIL-1:0] margin_direction_out,
  output logic [2:0] rail_state_sel_out,
  output logic [bgl_pkg::NRAIL-1:0] sequence_wait_fault_out,
  output logic irq_out
);

  // ***************************************************
  // Decoding helpers
  // ***************************************************
  function automatic logic pick(input logic [3:0] f,
                                input logic [bgl_pkg::NGI-1:0] g);
    return f[3] & g[f[2:0]];
  endfunction

  // An empty term is false so an unconfigured path never asserts
  function automatic logic term_eval(
      input bgl_pkg::bgl_term_s t, input logic [5:0] ty,
      input logic [bgl_pkg::NOUT-1:0] o, input logic [bgl_pkg::NGI-1:0] g,
      input bgl_pkg::bgl_rail_t [bgl_pkg::NTYPE-1:0] fl);
    bgl_pkg::bgl_rail_t rv;
    rv = (ty < bgl_pkg::NTYPE_CODE) ? fl[ty] : '0;
    return (|{t.rails, t.gis, t.outs}) && (&(o | ~t.outs)) &&
           (&(g | ~t.gis)) && (&(rv | ~t.rails));
  endfunction

  // ***************************************************
  // Register file
  // ***************************************************
  bgl_pkg::bgl_cfg_s cfg_q [bgl_pkg::NOUT];
  bgl_pkg::bgl_term_s term0_q [bgl_pkg::NOUT];
  bgl_pkg::bgl_term_s term1_q [bgl_pkg::NOUT];
  logic [bgl_pkg::NGI-1:0] gi_pol_q;
  logic [15:0] special_q;
  bgl_pkg::bgl_rail_t mrg_mask_q;
  logic [27:0] seq_lim_q;
  logic [bgl_pkg::ST_W-1:0] stat_q;
  logic [bgl_pkg::ST_W-1:0] mask_q;
  logic clr_cmd_q;
  logic [31:0] rd_d;
  logic [bgl_pkg::NOUT-1:0] pin_q;
  logic [bgl_pkg::NGI-1:0] gi;
  logic [2:0] out_idx;
  logic [1:0] out_sel;

  assign out_idx = addr_in[4:2];
  assign out_sel = addr_in[1:0];

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < bgl_pkg::NOUT; i++) begin
        cfg_q[i] <= '0;
        term0_q[i] <= '0;
        term1_q[i] <= '0;
      end
    end else if (wr_in && !addr_in[5]) begin
      case (out_sel)
        bgl_pkg::SEL_TERM0: term0_q[out_idx] <= wr_data_in[27:0];
        bgl_pkg::SEL_TERM1: term1_q[out_idx] <= wr_data_in[27:0];
        bgl_pkg::SEL_CFG: cfg_q[out_idx] <= wr_data_in[29:0];
        default: ;
      endcase
    end
  end

  // One index field per role makes a second pin per role impossible
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gi_pol_q <= '0;
      special_q <= '0;
      mrg_mask_q <= '0;
      seq_lim_q <= '0;
      mask_q <= '0;
    end else if (wr_in) begin
      case (addr_in)
        bgl_pkg::A_GI_POL: gi_pol_q <= wr_data_in[7:0];
        bgl_pkg::A_SPECIAL: special_q <= wr_data_in[15:0];
        bgl_pkg::A_MRG_MASK: mrg_mask_q <= wr_data_in[11:0];
        bgl_pkg::A_SEQ_LIM: seq_lim_q <= wr_data_in[27:0];
        bgl_pkg::A_IRQ_MASK: mask_q <= wr_data_in[bgl_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end

  // Clear command is a one-cycle pulse from a write of bit 0
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clr_cmd_q <= 1'b0;
    end else begin
      clr_cmd_q <= wr_in && addr_in == bgl_pkg::A_CLR_CMD && wr_data_in[0];
    end
  end

  always_comb begin
    rd_d = '0;
    if (!addr_in[5]) begin
      case (out_sel)
        bgl_pkg::SEL_TERM0: rd_d[27:0] = term0_q[out_idx];
        bgl_pkg::SEL_TERM1: rd_d[27:0] = term1_q[out_idx];
        bgl_pkg::SEL_CFG: rd_d[29:0] = cfg_q[out_idx];
        default: rd_d = '0;
      endcase
    end else begin
      case (addr_in)
        bgl_pkg::A_GI_POL: rd_d[7:0] = gi_pol_q;
        bgl_pkg::A_SPECIAL: rd_d[15:0] = special_q;
        bgl_pkg::A_MRG_MASK: rd_d[11:0] = mrg_mask_q;
        bgl_pkg::A_SEQ_LIM: rd_d[27:0] = seq_lim_q;
        bgl_pkg::A_IRQ_STAT: rd_d[bgl_pkg::ST_W-1:0] = stat_q;
        bgl_pkg::A_IRQ_MASK: rd_d[bgl_pkg::ST_W-1:0] = mask_q;
        bgl_pkg::A_STATE: begin
          rd_d[7:0] = pin_q;
          rd_d[bgl_pkg::ROW_GI_LSB +: 8] = gi;
          rd_d[bgl_pkg::ROW_CODE_LSB +: 3] = rail_state_sel_out;
        end
        default: rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= rd_in ? rd_d : '0;
    end
  end

  // ***************************************************
  // Input conditioning and special roles
  // ***************************************************
  logic seq_src;
  logic clr_pin;
  logic mrg_en;
  logic mrg_low;

  assign gi = general_input_in ~^ gi_pol_q;
  assign seq_src = pick(special_q[bgl_pkg::SF_SEQ +: 4], gi);
  assign clr_pin = pick(special_q[bgl_pkg::SF_CLR +: 4], gi);
  assign mrg_en = pick(special_q[bgl_pkg::SF_MEN +: 4], gi);
  assign mrg_low = pick(special_q[bgl_pkg::SF_MDIR +: 4], gi);

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      margin_active_out <= '0;
      margin_direction_out <= '0;
      rail_state_sel_out <= '0;
    end else begin
      margin_active_out <= {bgl_pkg::NRAIL{mrg_en}} & mrg_mask_q;
      margin_direction_out <= {bgl_pkg::NRAIL{mrg_en & mrg_low}} &
                              mrg_mask_q;
      rail_state_sel_out <= gi[2:0];
    end
  end

  // ***************************************************
  // Sequence wait limit per rail
  // ***************************************************
  logic [bgl_pkg::NRAIL-1:0] seq_fault;

  generate
    for (genvar r = 0; r < bgl_pkg::NRAIL; r++) begin : g_rail
      logic armed_q;
      logic pg_q;
      logic [15:0] ticks_q;
      logic [9:0] pre_q;
      logic on;
      logic pg;
      assign pg = rail_flags_in[bgl_pkg::T_PWR_GOOD][r];
      assign on = seq_lim_q[bgl_pkg::LIM_RAIL_LSB + r] &&
                  seq_lim_q[bgl_pkg::LIM_LSB +: 16] != 16'h0000;
      always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          armed_q <= 1'b0;
          pg_q <= 1'b0;
          ticks_q <= '0;
          pre_q <= '0;
          seq_fault[r] <= 1'b0;
        end else begin
          pg_q <= pg;
          if (!pg || !on) begin
            armed_q <= 1'b0;
            seq_fault[r] <= 1'b0;
          end else if (pg && !pg_q) begin
            armed_q <= 1'b1;
            ticks_q <= '0;
            pre_q <= '0;
          end else if (armed_q) begin
            if (seq_src) begin
              armed_q <= 1'b0;
            end else if (ticks_q == seq_lim_q[bgl_pkg::LIM_LSB +: 16]) begin
              armed_q <= 1'b0;
              seq_fault[r] <= 1'b1;
            end else if (pre_q == 10'(bgl_pkg::TICK_CYC - 1)) begin
              pre_q <= '0;
              ticks_q <= ticks_q + 16'h0001;
            end else begin
              pre_q <= pre_q + 10'h001;
            end
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sequence_wait_fault_out <= '0;
    end else begin
      sequence_wait_fault_out <= seq_fault;
    end
  end

  // ***************************************************
  // Rail flags, live and sticky
  // ***************************************************
  bgl_pkg::bgl_rail_t [bgl_pkg::NLIVE-1:0] live;
  bgl_pkg::bgl_rail_t [bgl_pkg::NLIVE-1:0] sticky_q;
  bgl_pkg::bgl_rail_t [bgl_pkg::NTYPE-1:0] flags;

  // Turn-on overtime arrives as its own live type from the engine
  assign live = {seq_fault, margin_direction_out, margin_active_out,
                 rail_flags_in};
  assign flags = {sticky_q, live};

  // A flag raised in the cycle of a clear still sets the sticky copy
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sticky_q <= '0;
    end else begin
      for (int t = 0; t < bgl_pkg::NLIVE; t++) begin
        sticky_q[t] <= live[t] |
                       (sticky_q[t] & {bgl_pkg::NRAIL{
                        !(clr_pin || clr_cmd_q)}});
      end
    end
  end

  // ***************************************************
  // Output logic with delays
  // ***************************************************
  generate
    for (genvar i = 0; i < bgl_pkg::NOUT; i++) begin : g_out
      bgl_pkg::bgl_cfg_s c;
      bgl_pkg::bgl_dly_e st_q;
      logic res_q;
      logic tgt_q;
      logic [11:0] cnt_q;
      logic [9:0] pre_q;
      logic t0;
      logic t1;
      logic raw;
      logic need;
      logic lvl;
      logic done;
      assign c = cfg_q[i];
      assign t0 = term_eval(term0_q[i], c.type0, pin_q, gi, flags);
      assign t1 = term_eval(term1_q[i], c.type1, pin_q, gi, flags);
      assign raw = c.sm_mode ? (res_q ? t0 : t1) : (t0 | t1);
      assign need = (raw ? c.dly_assert : c.dly_deassert) &&
                    c.delay != 12'h000;
      assign done = pre_q == 10'(bgl_pkg::TICK_CYC - 1) &&
                    cnt_q == c.delay - 12'h001;
      assign lvl = c.active_high ? pin_q[i] : !pin_q[i];

      always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          res_q <= 1'b0;
        end else begin
          res_q <= raw;
        end
      end

      always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          st_q <= bgl_pkg::BGL_IDLE;
          pin_q[i] <= 1'b0;
          tgt_q <= 1'b0;
          cnt_q <= '0;
          pre_q <= '0;
        end else begin
          if (pre_q == 10'(bgl_pkg::TICK_CYC - 1)) begin
            pre_q <= '0;
            cnt_q <= cnt_q + 12'h001;
          end else begin
            pre_q <= pre_q + 10'h001;
          end
          case (st_q)
            bgl_pkg::BGL_IDLE: begin
              pre_q <= '0;
              cnt_q <= '0;
              if (raw != pin_q[i]) begin
                if (!need) begin
                  pin_q[i] <= raw;
                  if (c.ignore && c.delay != 12'h000) begin
                    st_q <= bgl_pkg::BGL_HOLD;
                  end
                end else begin
                  tgt_q <= raw;
                  st_q <= bgl_pkg::BGL_WAIT;
                end
              end
            end
            bgl_pkg::BGL_WAIT: begin
              if (!c.ignore && raw == pin_q[i]) begin
                st_q <= bgl_pkg::BGL_IDLE;
              end else if (done) begin
                pin_q[i] <= tgt_q;
                pre_q <= '0;
                cnt_q <= '0;
                st_q <= c.ignore ? bgl_pkg::BGL_HOLD : bgl_pkg::BGL_IDLE;
              end
            end
            bgl_pkg::BGL_HOLD: begin
              if (done) begin
                st_q <= bgl_pkg::BGL_IDLE;
              end
            end
            default: st_q <= bgl_pkg::BGL_IDLE;
          endcase
        end
      end

      always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          logic_output_out[i] <= 1'b0;
          logic_output_oe_out[i] <= 1'b0;
        end else begin
          logic_output_out[i] <= c.open_drain ? 1'b0 : lvl;
          logic_output_oe_out[i] <= c.open_drain ? !lvl : 1'b1;
        end
      end
    end
  endgenerate

  // ***************************************************
  // Interrupt status
  // ***************************************************
  logic [bgl_pkg::NOUT-1:0] pin_old_q;
  logic [bgl_pkg::NRAIL-1:0] fault_old_q;
  logic [bgl_pkg::ST_W-1:0] evt;
  logic [bgl_pkg::ST_W-1:0] w1c;

  assign evt = {seq_fault & ~fault_old_q, pin_q ^ pin_old_q};
  assign w1c = (wr_in && addr_in == bgl_pkg::A_IRQ_STAT) ?
               wr_data_in[bgl_pkg::ST_W-1:0] : '0;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_old_q <= '0;
      fault_old_q <= '0;
      stat_q <= '0;
      irq_out <= 1'b0;
    end else begin
      pin_old_q <= pin_q;
      fault_old_q <= seq_fault;
      stat_q <= evt | (stat_q & ~w1c);
      irq_out <= |(stat_q & mask_q);
    end
  end

endmodule

`default_nettype wire

//--- dv/bgl_board.sv
// Board model around the output logic: general inputs, rail flags, pins.
// Assumes every logic output pin carries a pull-up on the board.
`timescale 1ns/100ps
`default_nettype none
module bgl_board (
  input wire logic [7:0] gi_cmd_in,
  input wire bgl_pkg::bgl_rail_t [bgl_pkg::NEXT-1:0] flag_cmd_in,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_oe_in,
  output logic [7:0] general_input_out,
  output bgl_pkg::bgl_rail_t [bgl_pkg::NEXT-1:0] rail_flags_out,
  output logic [7:0] pin_level_out
);
  assign general_input_out = gi_cmd_in;
  assign rail_flags_out = flag_cmd_in;
  // A released pin floats to the pull-up, never to the last driven value
  assign pin_level_out = (pin_in & pin_oe_in) | ~pin_oe_in;
endmodule
`default_nettype wire

//--- dv/bgl_logic_sva.sv
// Port-level checker for the boolean output logic.
// Assumes binding to bgl_logic; shadows a few registers from the write port.
`timescale 1ns/100ps
`default_nettype none
module bgl_logic_chk (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [5:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rd_data_out,
  input wire logic [7:0] general_input_in,
  input wire logic [7:0] logic_output_out,
  input wire logic [7:0] logic_output_oe_out,
  input wire logic [11:0] margin_active_out,
  input wire logic [11:0] margin_direction_out,
  input wire logic [2:0] rail_state_sel_out,
  input wire logic [11:0] sequence_wait_fault_out,
  input wire logic irq_out
);
  // ****
  // Register shadows
  // ****
  logic [7:0] pol_q;
  logic [15:0] sp_q;
  logic [11:0] mm_q;
  logic [11:0] lr_q;
  logic [19:0] im_q;
  logic [7:0] gc;
  logic men;
  logic mdir;
  logic [11:0] ma_x;
  logic [11:0] md_x;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pol_q <= 8'h0;
      sp_q <= 16'h0;
      mm_q <= 12'h0;
      lr_q <= 12'h0;
      im_q <= 20'h0;
    end else if (wr_in) begin
      case (addr_in)
        6'h20: pol_q <= wr_data_in[7:0];
        6'h21: sp_q <= wr_data_in[15:0];
        6'h22: mm_q <= wr_data_in[11:0];
        // A rail with a zero limit never arms
        6'h23: lr_q <= (|wr_data_in[15:0]) ? wr_data_in[27:16] : 12'h0;
        6'h25: im_q <= wr_data_in[19:0];
        default: ;
      endcase
    end
  end

  assign gc = general_input_in ^ ~pol_q;
  assign men = sp_q[11] & gc[sp_q[10:8]];
  assign mdir = sp_q[15] & gc[sp_q[14:12]];
  assign ma_x = men ? mm_q : 12'h0;
  assign md_x = (men & mdir) ? mm_q : 12'h0;

  // ****
  // Assertions
  // ****
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  a_rd_idle_zero: assert property (!$past(rd_in) |-> rd_data_out == 32'h0)
    else $error("read data outside its slot");
  a_pol_read_back: assert property (
    rd_in && addr_in == 6'h20 |=> rd_data_out == {24'h0, $past(pol_q)})
    else $error("polarity read back wrong");
  a_rd_unmapped_zero: assert property (rd_in && (addr_in > 6'h27 ||
    (!addr_in[5] && addr_in[1:0] == 2'h3)) |=> rd_data_out == 32'h0)
    else $error("unmapped read not zero");
  a_state_sel_follow: assert property (
    $past(nrst_in) |-> rail_state_sel_out == $past(gc[2:0]))
    else $error("state select code wrong");
  a_margin_active_set: assert property (
    ma_x == $past(ma_x) && ma_x == $past(ma_x, 2)
    |-> margin_active_out == ma_x)
    else $error("margin active wrong");
  a_margin_dir_set: assert property (
    md_x == $past(md_x) && md_x == $past(md_x, 2)
    |-> margin_direction_out == md_x)
    else $error("margin direction wrong");
  a_dir_within_active: assert property (
    (margin_direction_out & ~margin_active_out) == 12'h0)
    else $error("direction on a rail not in margin");
  // A dropped rail's fault takes two edges to leave the registered output
  a_fault_armed_rails: assert property (
    (sequence_wait_fault_out & ~$past(lr_q, 2)) == 12'h0)
    else $error("wait fault on a rail without limit");
  a_irq_needs_mask: assert property (irq_out |-> $past(im_q) != 20'h0)
    else $error("interrupt with empty mask");
  a_reset_drive_idle: assert property (
    $past(nrst_in) && !$past(nrst_in, 2)
    |-> logic_output_out == 8'hff && logic_output_oe_out == 8'hff)
    else $error("outputs not idle after reset");

  c_irq_rise: cover property ($rose(irq_out));
  c_fault_rise: cover property ($rose(|sequence_wait_fault_out));
  c_margin_low: cover property (|margin_direction_out);
endmodule
`default_nettype wire

//--- dv/bgl_logic_tb_top.sv
// Self-checking bench for the boolean output logic.
// Assumes the board model and the checker compile before this file.
`timescale 1ns/100ps
`default_nettype none
module bgl_logic_tb_top;
  logic sys_clk_in, nrst_in, wr, rd, irq;
  logic [5:0] addr;
  logic [31:0] wdat, rdat, v;
  logic [7:0] gcmd, gi, pin, oe, lvl;
  bgl_pkg::bgl_rail_t [bgl_pkg::NEXT-1:0] fcmd, fl;
  logic [11:0] ma, md, flt;
  logic [2:0] sel;
  logic [7:0] smv [5] = '{8'h40, 8'hc0, 8'h40, 8'h0, 8'h40};
  logic sme [5] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h0};
  int failures, check_count, n;

  bgl_logic uut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .addr_in(addr),
    .wr_data_in(wdat), .wr_in(wr), .rd_in(rd), .rd_data_out(rdat),
    .general_input_in(gi), .rail_flags_in(fl), .logic_output_out(pin),
    .logic_output_oe_out(oe), .margin_active_out(ma),
    .margin_direction_out(md), .rail_state_sel_out(sel),
    .sequence_wait_fault_out(flt), .irq_out(irq));
  bgl_board board (.gi_cmd_in(gcmd), .flag_cmd_in(fcmd), .pin_in(pin),
    .pin_oe_in(oe), .general_input_out(gi), .rail_flags_out(fl),
    .pin_level_out(lvl));

  initial begin
    sys_clk_in = 1'h0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  // ****
  // Tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
  endtask
  task automatic wrr(input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    wdat <= d;
    wr <= 1'h1;
    @(posedge sys_clk_in);
    wr <= 1'h0;
  endtask
  task automatic rdd(input logic [5:0] a);
    @(posedge sys_clk_in);
    addr <= a;
    rd <= 1'h1;
    @(posedge sys_clk_in);
    rd <= 1'h0;
    @(negedge sys_clk_in);
    v = rdat;
  endtask
  task automatic g(input logic [7:0] x);
    @(posedge sys_clk_in);
    gcmd <= x;
  endtask
  task automatic f(input int t, input int r, input logic x);
    @(posedge sys_clk_in);
    fcmd[t][r] <= x;
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****
  // Scenarios
  // ****
  initial begin
    nrst_in = 1'h0;
    wr = 1'h0;
    rd = 1'h0;
    addr = 6'h0;
    wdat = 32'h0;
    gcmd = 8'h0;
    fcmd = '0;
    failures = 0;
    check_count = 0;
    repeat (16) @(posedge sys_clk_in);
    nrst_in <= 1'h1;
    cyc(2);
    chk(32'({lvl, oe}), 32'hffff);
    wrr(6'h20, 32'hff);
    rdd(6'h20);
    chk(v, 32'hff);
    rdd(6'h3f);
    chk(v, 32'h0);
    rdd(6'h03);
    chk(v, 32'h0);
    // Output 0 is gi0 or (gi1 and gi2); output 5 copies output 0
    wrr(6'h00, 32'h100);
    wrr(6'h01, 32'h600);
    wrr(6'h02, 32'h10000);
    wrr(6'h14, 32'h1);
    wrr(6'h16, 32'h10000);
    for (int i = 0; i < 8; i++) begin
      g(8'(i));
      cyc(3);
      chk(32'(lvl[0]), 32'(i[0] | (i[1] & i[2])));
      chk(32'(lvl[5]), 32'(i[0] | (i[1] & i[2])));
      chk(32'(sel), 32'(i[2:0]));
    end
    wrr(6'h20, 32'h0);
    g(8'hfe);
    cyc(3);
    chk(32'({sel, lvl[0]}), 32'h3);
    // Open drain releases a high level to the pull-up and drives a low one
    wrr(6'h02, 32'h30000);
    cyc(2);
    chk(32'({lvl[0], oe[0]}), 32'h2);
    g(8'hff);
    cyc(3);
    chk(32'({lvl[0], oe[0]}), 32'h1);
    wrr(6'h02, 32'h10000);
    wrr(6'h20, 32'hff);
    g(8'h0);
    // Output 1: good on rails 3 and 5, or sticky overvoltage on rail 3
    wrr(6'h04, 32'h280000);
    wrr(6'h05, 32'h80000);
    wrr(6'h06, 32'h104c0);
    f(0, 3, 1'h1);
    cyc(3);
    chk(32'(lvl[1]), 32'h0);
    f(0, 5, 1'h1);
    cyc(3);
    chk(32'(lvl[1]), 32'h1);
    f(0, 3, 1'h0);
    f(0, 5, 1'h0);
    f(1, 3, 1'h1);
    f(1, 3, 1'h0);
    cyc(4);
    chk(32'(lvl[1]), 32'h1);
    wrr(6'h26, 32'h1);
    cyc(3);
    chk(32'(lvl[1]), 32'h0);
    f(1, 3, 1'h1);
    f(1, 3, 1'h0);
    cyc(3);
    chk(32'(lvl[1]), 32'h1);
    wrr(6'h21, 32'hd0);
    g(8'h20);
    g(8'h0);
    cyc(3);
    chk(32'(lvl[1]), 32'h0);
    // Path 1 now watches turn-on overtime on rail 3
    wrr(6'h06, 32'h10140);
    f(5, 3, 1'h1);
    cyc(3);
    chk(32'(lvl[1]), 32'h1);
    f(5, 3, 1'h0);
    cyc(3);
    chk(32'(lvl[1]), 32'h0);
    // Output 2: gi3 with one tick delay on assertion only
    wrr(6'h08, 32'h800);
    wrr(6'h0a, 32'h51000);
    g(8'h8);
    cyc(500);
    g(8'h0);
    cyc(1100);
    chk(32'(lvl[2]), 32'h0);
    g(8'h8);
    cyc(990);
    chk(32'(lvl[2]), 32'h0);
    cyc(20);
    chk(32'(lvl[2]), 32'h1);
    g(8'h0);
    cyc(3);
    chk(32'(lvl[2]), 32'h0);
    // Output 3: gi4, one tick both ways, inputs ignored during delay
    wrr(6'h0c, 32'h1000);
    wrr(6'h0e, 32'h57000);
    g(8'h10);
    g(8'h0);
    cyc(1050);
    chk(32'(lvl[3]), 32'h1);
    cyc(900);
    chk(32'(lvl[3]), 32'h1);
    cyc(2200);
    chk(32'(lvl[3]), 32'h0);
    // Output 4: state machine, path 0 is gi6, path 1 is gi7
    wrr(6'h10, 32'h4000);
    wrr(6'h11, 32'h8000);
    wrr(6'h12, 32'h18000);
    for (int k = 0; k < 5; k++) begin
      g(smv[k]);
      cyc(3);
      chk(32'(lvl[4]), 32'(sme[k]));
    end
    // Margin enable on gi1, direction on gi2, rails 0 to 3
    wrr(6'h22, 32'hf);
    wrr(6'h21, 32'ha9d0);
    for (int k = 0; k < 4; k++) begin
      g(8'(k * 2));
      cyc(3);
      chk(32'(ma), (k == 1 || k == 3) ? 32'hf : 32'h0);
      chk(32'(md), (k == 3) ? 32'hf : 32'h0);
    end
    // Wait limit of two ticks on rail 0, source on gi7
    g(8'h0);
    wrr(6'h23, 32'h10002);
    wrr(6'h21, 32'ha9df);
    wrr(6'h25, 32'h100);
    wrr(6'h24, 32'hfffff);
    f(0, 0, 1'h1);
    n = 0;
    while (flt[0] !== 1'h1 && n < 2100) begin
      cyc(1);
      n++;
    end
    chk(32'(n >= 1990 && n <= 2010), 32'h1);
    if (n >= 2100)
      stop_test;
    cyc(2);
    chk(32'(irq), 32'h1);
    wrr(6'h24, 32'h100);
    cyc(2);
    chk(32'(irq), 32'h0);
    rdd(6'h24);
    chk(32'(v[19:8]), 32'h0);
    wrr(6'h25, 32'hff);
    g(8'h1);
    cyc(3);
    chk(32'(irq), 32'h1);
    wrr(6'h25, 32'h0);
    cyc(2);
    chk(32'(irq), 32'h0);
    rdd(6'h24);
    chk(32'(v[0]), 32'h1);
    wrr(6'h24, 32'hfffff);
    f(0, 0, 1'h0);
    cyc(3);
    chk(32'(flt[0]), 32'h0);
    f(0, 0, 1'h1);
    cyc(500);
    g(8'h80);
    cyc(2000);
    chk(32'(flt[0]), 32'h0);
    stop_test;
  end

  // A hang counts as a failure and still reaches the report
  initial begin
    repeat (40000) @(posedge sys_clk_in);
    failures++;
    $display("mismatch at %0t: run did not finish", $time);
    stop_test;
  end
endmodule

bind bgl_logic bgl_logic_chk chk_i (.sys_clk_in(sys_clk_in),
  .nrst_in(nrst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
  .general_input_in(general_input_in), .logic_output_out(logic_output_out),
  .logic_output_oe_out(logic_output_oe_out),
  .margin_active_out(margin_active_out),
  .margin_direction_out(margin_direction_out),
  .rail_state_sel_out(rail_state_sel_out),
  .sequence_wait_fault_out(sequence_wait_fault_out), .irq_out(irq_out));
`default_nettype wire
